/* design/pemux_spike.v */
// spike filter: output follows input only after it held steady
// assumes input is already synchronised to clk
module pemux_spike #(
  parameter HOLD = 1
) (
  input wire clk,
  input wire rst_n,
  input wire din,
  output reg dout
);
  reg [3:0] cnt;
  reg last;

  // count cycles the new level has stood, accept after HOLD
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      cnt <= 4'h0;
      last <= 1'b1;
      dout <= 1'b1;
    end
    else if (din != last)
    begin
      last <= din;
      cnt <= 4'h0;
    end
    else if (cnt >= HOLD[3:0])
      dout <= last;
    else
      cnt <= cnt + 4'h1;
  end
endmodule

/* design/pemux_sync.v */
// two-flop synchroniser for a group of pin inputs
// assumes pins are asynchronous to SYS_CLK
module pemux_sync #(
  parameter WIDTH = 4
) (
  input wire clk,
  input wire rst_n,
  input wire [WIDTH-1:0] din,
  output reg [WIDTH-1:0] dout
);
  reg [WIDTH-1:0] stage1;

  // first stage feeds only the second; reset to idle-high pin level
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      stage1 <= {WIDTH{1'b1}};
      dout <= {WIDTH{1'b1}};
    end
    else
    begin
      stage1 <= din;
      dout <= stage1;
    end
  end
endmodule

/* design/pemux_top.v */
// port E alternate function override logic and mcu control register
// assumes core bus: address, write strobe, io-space flag, read mux
// Contract
// (RULE_01) SPI2 slave forces PE3 to input; pull-up still from latch bit.
// (RULE_02) Two-wire enable detaches PE1 as open-drain clock line.
// (RULE_03) Two-wire enable detaches PE0 as open-drain data line.
// (RULE_04) Two-wire pin inputs reject pulses shorter than 50 ns.
// (RULE_05) Pull-up override value is latch bit AND pull-up disable.
// (RULE_06) SPI2 master drives PE3 from its data output.
// (RULE_07) PE1/PE0 output overrides from two-wire drive and comparator.
// (RULE_08) Input enable override from pin-change mask, group enable, adc.
// (RULE_09) Global pull-up disable turns off all port pull-ups.
// (RULE_10) Software sets both sleep bits, then bit alone within four.
// (RULE_11) Sleep-off bit acts for three cycles after set; sleep kills detector.
// (RULE_12) Hardware clears sleep-off bit three cycles after set.
// (RULE_13) Vector base is flash start or boot start per select bit.
// (RULE_14) Software writes unlock, then select with unlock zero within four.
// (RULE_15) Interrupts blocked from unlock until after next instruction.
// (RULE_16) Blocking leaves the global interrupt flag untouched.
// (RULE_17) Lock bits block interrupts in the section lacking the vectors.
// (RULE_18) Register at data 0x55, io 0x35.
// (RULE_19) Unlock bit cleared four cycles after write or on select write.
// (RULE_20) Sleep-off write outside its window is ignored.
`include "pemux_defs.vh"
module pemux_top #(
  parameter PC_W = 14,
  parameter BOOT_BASE_W = 2
) (
  input wire SYS_CLK,
  input wire RST_N,
  // core register access
  input wire [7:0] ADDR,
  input wire IO_SPACE,
  input wire WR_EN,
  input wire RD_EN,
  input wire [7:0] WDATA,
  output reg [7:0] RDATA,
  // core status
  input wire SLEEP_EXEC,
  input wire INSTR_DONE,
  input wire IN_BOOT_SECTION,
  input wire [BOOT_BASE_W-1:0] BOOT_SIZE_FUSES,
  input wire APPLICATION_LOCK_BIT,
  input wire BOOTLOADER_LOCK_BIT,
  output reg IRQ_BLOCK,
  output reg [PC_W-1:0] VECTOR_BASE,
  output reg BROWNOUT_DETECTOR_OFF,
  // general port settings for PE3..PE0
  input wire [3:0] PORTE_DIR,
  input wire [3:0] PORTE_OUT_LATCH,
  input wire [3:0] PIN_CHANGE_MASK,
  input wire PIN_CHANGE_GROUP3_ENABLE,
  input wire ADC_CH6_DIGITAL_DISABLE,
  input wire ADC_CH7_DIGITAL_DISABLE,
  // peripherals
  input wire SPI_UNIT2_ENABLE,
  input wire SPI_MASTER_SELECT,
  input wire SPI_UNIT2_DATA_OUT,
  input wire TWOWIRE_ENABLE,
  input wire TWOWIRE_CLOCK_DRIVE,
  input wire TWOWIRE_DATA_DRIVE,
  input wire COMP_OUT_ENABLE,
  input wire COMP_OUT,
  // pins
  input wire [3:0] PE_IN,
  output reg [3:0] PE_OUT,
  output reg [3:0] PE_OE_N,
  output reg [3:0] PE_PULLUP,
  output reg [3:0] PE_DIG_IN,
  output reg TWOWIRE1_CLOCK_PIN,
  output reg TWOWIRE1_DATA_PIN
);
  reg bo_sleep;
  reg bo_unlock;
  reg pull_disable;
  reg vec_sel;
  reg vec_unlock;
  reg [2:0] bo_unlock_cnt;
  reg [2:0] bo_active_cnt;
  reg [2:0] vec_unlock_cnt;
  reg block_pending;
  reg [3:0] pull_ovr_en;
  reg [3:0] pull_ovr_val;
  reg [3:0] dir_ovr_en;
  reg [3:0] out_ovr_en;
  reg [3:0] out_ovr_val;
  reg [3:0] din_ovr_en;
  reg [3:0] din_ovr_val;
  reg [3:0] next_pull;
  reg [3:0] next_dir;
  reg [3:0] next_out;
  reg [3:0] next_din;
  wire [3:0] pe_sync;
  wire scl_filt;
  wire sda_filt;
  wire hit;
  wire wr_hit;
  wire bo_seq_open;
  wire lock_block;

  // address match in either space
  function match;
    input [7:0] a;
    input io;
    begin
      if (io)
        match = (a == `PEMUX_MCUCTL_IO_ADDR);
      else
        match = (a == `PEMUX_MCUCTL_DATA_ADDR);
    end
  endfunction

  assign hit = match(ADDR, IO_SPACE); // [RULE_18]
  assign wr_hit = WR_EN & hit;
  assign bo_seq_open = bo_unlock_cnt != 3'd0;

  // pin input synchroniser
  pemux_sync #(
    .WIDTH(4)
  ) u_sync (
    .clk(SYS_CLK),
    .rst_n(RST_N),
    .din(PE_IN),
    .dout(pe_sync)
  );

  // two-wire spike filters on clock and data
  pemux_spike #(
    .HOLD(`PEMUX_SPIKE_CYCLES)
  ) u_scl_filt (
    .clk(SYS_CLK),
    .rst_n(RST_N),
    .din(pe_sync[1]),
    .dout(scl_filt)
  ); // [RULE_04]

  pemux_spike #(
    .HOLD(`PEMUX_SPIKE_CYCLES)
  ) u_sda_filt (
    .clk(SYS_CLK),
    .rst_n(RST_N),
    .din(pe_sync[0]),
    .dout(sda_filt)
  ); // [RULE_04]

  // mcu control register and timed sequences
  always @(posedge SYS_CLK)
  begin
    if (!RST_N)
    begin
      bo_sleep <= 1'b0;
      bo_unlock <= 1'b0;
      pull_disable <= 1'b0;
      vec_sel <= 1'b0;
      vec_unlock <= 1'b0;
      bo_unlock_cnt <= 3'd0;
      bo_active_cnt <= 3'd0;
      vec_unlock_cnt <= 3'd0;
    end
    else
    begin
      // sleep-off unlock window
      if (wr_hit && WDATA[`PEMUX_BIT_BOSLP] && WDATA[`PEMUX_BIT_BOUNLK])
      begin
        bo_unlock <= 1'b1;
        bo_unlock_cnt <= `PEMUX_UNLOCK_CYCLES;
      end
      else if (bo_seq_open)
      begin
        bo_unlock_cnt <= bo_unlock_cnt - 3'd1;
        if (bo_unlock_cnt == 3'd1)
          bo_unlock <= 1'b0;
      end
      // set sleep-off only inside window
      if (wr_hit && bo_seq_open && WDATA[`PEMUX_BIT_BOSLP] &&
          !WDATA[`PEMUX_BIT_BOUNLK]) // [RULE_20]
      begin
        bo_sleep <= 1'b1;
        bo_unlock <= 1'b0;
        bo_unlock_cnt <= 3'd0;
        bo_active_cnt <= `PEMUX_BOSLP_CYCLES;
      end
      else if (bo_active_cnt != 3'd0)
      begin
        bo_active_cnt <= bo_active_cnt - 3'd1;
        if (bo_active_cnt == 3'd1)
          bo_sleep <= 1'b0; // [RULE_12]
      end
      if (wr_hit)
        pull_disable <= WDATA[`PEMUX_BIT_PUDIS];
      // vector select change sequence
      if (wr_hit && vec_unlock && !WDATA[`PEMUX_BIT_VUNLK])
      begin
        vec_sel <= WDATA[`PEMUX_BIT_VSEL];
        vec_unlock <= 1'b0; // [RULE_19]
        vec_unlock_cnt <= 3'd0;
      end
      else if (wr_hit && WDATA[`PEMUX_BIT_VUNLK])
      begin
        vec_unlock <= 1'b1;
        vec_unlock_cnt <= `PEMUX_UNLOCK_CYCLES;
      end
      else if (vec_unlock_cnt != 3'd0)
      begin
        vec_unlock_cnt <= vec_unlock_cnt - 3'd1;
        if (vec_unlock_cnt == 3'd1)
          vec_unlock <= 1'b0; // [RULE_19]
      end
    end
  end

  // lock bit section blocking
  assign lock_block = (vec_sel & APPLICATION_LOCK_BIT & ~IN_BOOT_SECTION) |
    (~vec_sel & BOOTLOADER_LOCK_BIT & IN_BOOT_SECTION); // [RULE_17]

  // interrupt block, vector base, detector sleep-off; flag never touched
  always @(posedge SYS_CLK)
  begin
    if (!RST_N)
    begin
      block_pending <= 1'b0;
      IRQ_BLOCK <= 1'b0;
      VECTOR_BASE <= {PC_W{1'b0}};
      BROWNOUT_DETECTOR_OFF <= 1'b0;
      RDATA <= `PEMUX_MCUCTL_RESET;
    end
    else
    begin
      if (wr_hit && vec_unlock && !WDATA[`PEMUX_BIT_VUNLK])
        block_pending <= 1'b1;
      else if (INSTR_DONE)
        block_pending <= 1'b0;
      IRQ_BLOCK <= (wr_hit & WDATA[`PEMUX_BIT_VUNLK]) | vec_unlock |
        block_pending | lock_block; // [RULE_15] [RULE_16]
      if (vec_sel)
        VECTOR_BASE <= {BOOT_SIZE_FUSES, {(PC_W-BOOT_BASE_W){1'b0}}}
          ^ {1'b1, {(PC_W-1){1'b0}}}; // [RULE_13]
      else
        VECTOR_BASE <= {PC_W{1'b0}}; // [RULE_13]
      // sleep while active turns detector off for that sleep
      if (SLEEP_EXEC && bo_sleep)
        BROWNOUT_DETECTOR_OFF <= 1'b1; // [RULE_11]
      else if (!SLEEP_EXEC)
        BROWNOUT_DETECTOR_OFF <= 1'b0;
      if (RD_EN && hit)
        RDATA <= {1'b0, bo_sleep, bo_unlock, pull_disable, 2'b00,
          vec_sel, vec_unlock} & `PEMUX_MCUCTL_MASK;
      else
        RDATA <= 8'h00;
    end
  end

  // override signal table
  always @*
  begin
    pull_ovr_val = PORTE_OUT_LATCH & {4{pull_disable}}; // [RULE_05]
    pull_ovr_en[3] = SPI_UNIT2_ENABLE & SPI_MASTER_SELECT;
    pull_ovr_en[2] = SPI_UNIT2_ENABLE & SPI_MASTER_SELECT;
    pull_ovr_en[1] = TWOWIRE_ENABLE;
    pull_ovr_en[0] = COMP_OUT_ENABLE | TWOWIRE_ENABLE;
    dir_ovr_en = pull_ovr_en;
    // slave forces input on PE3
    dir_ovr_en[3] = SPI_UNIT2_ENABLE & ~SPI_MASTER_SELECT; // [RULE_01]
    out_ovr_en[3] = SPI_UNIT2_ENABLE & SPI_MASTER_SELECT; // [RULE_06]
    out_ovr_val[3] = SPI_UNIT2_DATA_OUT; // [RULE_06]
    out_ovr_en[2] = 1'b0;
    out_ovr_val[2] = 1'b0;
    out_ovr_en[1] = TWOWIRE_CLOCK_DRIVE; // [RULE_07]
    out_ovr_val[1] = TWOWIRE_ENABLE; // [RULE_07]
    out_ovr_en[0] = COMP_OUT_ENABLE | TWOWIRE_DATA_DRIVE; // [RULE_07]
    out_ovr_val[0] = COMP_OUT | TWOWIRE_ENABLE; // [RULE_07]
    din_ovr_val = PIN_CHANGE_MASK & {4{PIN_CHANGE_GROUP3_ENABLE}};
    din_ovr_en = din_ovr_val; // [RULE_08]
    din_ovr_en[3] = din_ovr_val[3] | ADC_CH7_DIGITAL_DISABLE; // [RULE_08]
    din_ovr_en[2] = din_ovr_val[2] | ADC_CH6_DIGITAL_DISABLE; // [RULE_08]
    // resolve direction, output, pull-up, digital input
    next_dir = (dir_ovr_en & 4'h0) | (~dir_ovr_en & PORTE_DIR);
    next_out = (out_ovr_en & out_ovr_val) | (~out_ovr_en & PORTE_OUT_LATCH);
    next_din = (din_ovr_en & din_ovr_val) | ~din_ovr_en;
    // pull-up when input with latch high, unless disabled
    next_pull = ~next_dir & PORTE_OUT_LATCH & {4{~pull_disable}}; // [RULE_09]
    // forced-input PE3 keeps pull-up from latch bit
    if (dir_ovr_en[3])
      next_pull[3] = PORTE_OUT_LATCH[3] & ~pull_disable; // [RULE_01]
    // two-wire pins: open drain, pull-ups from override value path
    if (TWOWIRE_ENABLE)
    begin
      next_dir[1] = out_ovr_en[1] & out_ovr_val[1]; // [RULE_02]
      next_out[1] = 1'b0; // [RULE_02]
      next_pull[1] = pull_ovr_val[1] & ~pull_disable; // [RULE_05]
      next_dir[0] = TWOWIRE_DATA_DRIVE; // [RULE_03]
      next_out[0] = 1'b0; // [RULE_03]
      next_pull[0] = pull_ovr_val[0] & ~pull_disable; // [RULE_05]
    end
  end

  // registered pin drive
  always @(posedge SYS_CLK)
  begin
    if (!RST_N)
    begin
      PE_OUT <= 4'h0;
      PE_OE_N <= 4'hf;
      PE_PULLUP <= 4'h0;
      PE_DIG_IN <= 4'hf;
      TWOWIRE1_CLOCK_PIN <= 1'b1;
      TWOWIRE1_DATA_PIN <= 1'b1;
    end
    else
    begin
      PE_OUT <= next_out;
      PE_OE_N <= ~next_dir;
      PE_PULLUP <= next_pull;
      PE_DIG_IN <= next_din & pe_sync;
      TWOWIRE1_CLOCK_PIN <= scl_filt; // [RULE_04]
      TWOWIRE1_DATA_PIN <= sda_filt; // [RULE_04]
    end
  end
endmodule

/* include/pemux_defs.vh */
// constants for the port E pin override and mcu control block
// assumes a 20 MHz core clock and 8-bit register access by the core
`ifndef PEMUX_DEFS_VH
`define PEMUX_DEFS_VH
// register offsets, data space and i/o space
`define PEMUX_MCUCTL_DATA_ADDR 8'h55
`define PEMUX_IO_OFFSET 8'h20
`define PEMUX_MCUCTL_IO_ADDR 8'h35
`define PEMUX_MCUCTL_RESET 8'h00
// field positions
`define PEMUX_BIT_BOSLP 6
`define PEMUX_BIT_BOUNLK 5
`define PEMUX_BIT_PUDIS 4
`define PEMUX_BIT_VSEL 1
`define PEMUX_BIT_VUNLK 0
// readable bits mask
`define PEMUX_MCUCTL_MASK 8'h73
// timing counts in cycles
`define PEMUX_UNLOCK_CYCLES 3'd4
`define PEMUX_BOSLP_CYCLES 3'd3
// spike filter: 50 ns at 50 ns period, rounded up to whole cycles
`define PEMUX_SPIKE_NS 50
`define PEMUX_CLK_NS 50
`define PEMUX_SPIKE_CYCLES ((`PEMUX_SPIKE_NS + `PEMUX_CLK_NS - 1) / `PEMUX_CLK_NS)
`endif

/* tb/pemux_chk.sv */
// assertions on the port E overrides and mcu control outputs
// bound into pemux_top; sees only its ports
module pemux_chk #(
  parameter PC_W = 14
) (
  input logic SYS_CLK,
  input logic RST_N,
  input logic [7:0] ADDR,
  input logic IO_SPACE,
  input logic WR_EN,
  input logic RD_EN,
  input logic [7:0] WDATA,
  input logic [7:0] RDATA,
  input logic SLEEP_EXEC,
  input logic IN_BOOT_SECTION,
  input logic APPLICATION_LOCK_BIT,
  input logic BOOTLOADER_LOCK_BIT,
  input logic IRQ_BLOCK,
  input logic [PC_W-1:0] VECTOR_BASE,
  input logic BROWNOUT_DETECTOR_OFF,
  input logic SPI_UNIT2_ENABLE,
  input logic SPI_MASTER_SELECT,
  input logic SPI_UNIT2_DATA_OUT,
  input logic TWOWIRE_ENABLE,
  input logic TWOWIRE_CLOCK_DRIVE,
  input logic TWOWIRE_DATA_DRIVE,
  input logic COMP_OUT_ENABLE,
  input logic [3:0] PE_OUT,
  input logic [3:0] PE_OE_N
);
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!RST_N);
  logic hit;
  logic unl;
  logic nolk;
  // address match, vector unlock write, no lock bits
  assign hit = IO_SPACE ? (ADDR == 8'h35) : (ADDR == 8'h55);
  assign unl = WR_EN && hit && (WDATA[1:0] == 2'b01);
  assign nolk = !APPLICATION_LOCK_BIT && !BOOTLOADER_LOCK_BIT;
  AST_RD_ZERO:
    assert property ((!RD_EN || !hit) |=> RDATA == 8'h00)
    else $error("read data not zero");
  AST_UNL_BLK:
    assert property (unl |=> IRQ_BLOCK)
    else $error("unlock write did not block");
  AST_UNL_END:
    assert property (unl ##1 (!WR_EN && nolk)[*6] |-> !IRQ_BLOCK)
    else $error("block outlived unlock");
  AST_SEL_HOLD:
    assert property (unl ##1 !WR_EN ##1 (WR_EN && hit && !WDATA[0])
      |=> IRQ_BLOCK)
    else $error("block dropped at select");
  AST_LOCK_APP:
    assert property (APPLICATION_LOCK_BIT && !IN_BOOT_SECTION
      && VECTOR_BASE != 0 |=> IRQ_BLOCK)
    else $error("app lock not blocking");
  AST_SPI_SLV:
    assert property (SPI_UNIT2_ENABLE && !SPI_MASTER_SELECT |=> PE_OE_N[3])
    else $error("slave pin not input");
  AST_SPI_MST:
    assert property (SPI_UNIT2_ENABLE && SPI_MASTER_SELECT
      |=> PE_OUT[3] == $past(SPI_UNIT2_DATA_OUT))
    else $error("master data not on pin");
  AST_SCL_OD:
    assert property (TWOWIRE_ENABLE |=> PE_OE_N[1] ==
      !$past(TWOWIRE_CLOCK_DRIVE) && (PE_OE_N[1] || !PE_OUT[1]))
    else $error("clock pin not open drain");
  AST_SDA_OD:
    assert property (TWOWIRE_ENABLE && !COMP_OUT_ENABLE
      |=> PE_OE_N[0] == !$past(TWOWIRE_DATA_DRIVE))
    else $error("data pin not open drain");
  AST_BOD_SLP:
    assert property ($rose(BROWNOUT_DETECTOR_OFF) |-> $past(SLEEP_EXEC))
    else $error("detector off outside sleep");
  cover property (unl ##1 !WR_EN ##1 (WR_EN && hit && !WDATA[0]));
  cover property (BROWNOUT_DETECTOR_OFF);
  cover property (TWOWIRE_ENABLE && !PE_OE_N[1]);
endmodule

/* tb/pemux_core.sv */
// core bus model: loads, stores and the timed unlock sequences
// assumes the block samples on rising edges; drives on falling edges
module pemux_core (
  input wire logic clk,
  output logic [7:0] addr,
  output logic io,
  output logic wr,
  output logic rd,
  output logic [7:0] wdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] exp_q[$];
  // idle bus at time zero
  initial
  begin
    {addr, io, wr, rd, wdata} = 19'h0;
  end
  // one access, strobe held for a single rising edge
  task acc(input logic w, i, input logic [7:0] a, d);
    @(negedge clk);
    {addr, io, wr, rd, wdata} = {a, i, w, !w, d};
    @(negedge clk);
    {wr, rd} = 2'h0;
  endtask
  // read, noting the expected data before the strobe
  task rdx(input logic i, input logic [7:0] a, e);
    exp_q.push_back(e);
    acc(1'h0, i, a, 8'h00);
  endtask
  // sleep-off unlock, then the set after gap+1 idle cycles
  task bod_seq(input int gap);
    acc(1'h1, 1'h0, 8'h55, 8'h60);
    repeat (gap) @(negedge clk);
    acc(1'h1, 1'h1, 8'h35, 8'h40);
  endtask
  // vector unlock, then select with the unlock bit zero
  task vec_seq(input logic s);
    acc(1'h1, 1'h1, 8'h35, 8'h01);
    acc(1'h1, 1'h1, 8'h35, {6'h00, s, 1'h0});
  endtask
endmodule

/* tb/tb_pemux_top.sv */
// self-checking bench for the port E override and mcu control block
// needs pemux_top, pemux_core and pemux_chk compiled before it
`define CHK(a, e) \
  begin \
    n_tests++; \
    if ((a) !== (e)) \
    begin \
      mismatches++; \
      $display("Error at %0t: got %h expected %h", $time, a, e); \
    end \
  end
module tb_pemux_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic SYS_CLK = 1'h0, RST_N = 1'h0;
  logic [7:0] ADDR, WDATA, RDATA, exp_r;
  logic IO_SPACE, WR_EN, RD_EN, IRQ_BLOCK, BROWNOUT_DETECTOR_OFF;
  logic SLEEP_EXEC = 1'h0, INSTR_DONE = 1'h0, IN_BOOT_SECTION = 1'h0;
  logic [1:0] BOOT_SIZE_FUSES = 2'h1;
  logic APPLICATION_LOCK_BIT = 1'h0, BOOTLOADER_LOCK_BIT = 1'h0;
  logic [13:0] VECTOR_BASE;
  logic [3:0] PORTE_DIR = 4'h0, PORTE_OUT_LATCH = 4'h0;
  logic [3:0] PIN_CHANGE_MASK = 4'h0, PE_OUT, PE_OE_N, PE_PULLUP;
  logic PIN_CHANGE_GROUP3_ENABLE = 1'h0, ADC_CH6_DIGITAL_DISABLE = 1'h0;
  logic ADC_CH7_DIGITAL_DISABLE = 1'h0, SPI_UNIT2_ENABLE = 1'h0;
  logic SPI_MASTER_SELECT = 1'h0, SPI_UNIT2_DATA_OUT = 1'h0;
  logic TWOWIRE_ENABLE = 1'h0, TWOWIRE_CLOCK_DRIVE = 1'h0;
  logic TWOWIRE_DATA_DRIVE = 1'h0, COMP_OUT_ENABLE = 1'h0, COMP_OUT = 1'h0;
  logic [3:0] PE_DIG_IN, dx, ext = 4'hf;
  logic TWOWIRE1_CLOCK_PIN, TWOWIRE1_DATA_PIN, rd_s = 1'h0, bod_seen = 1'h0;
  logic [31:0] r;
  int seed = 20, mismatches = 0, n_tests = 0;
  // pin level: the block's driver where enabled, else the outside world
  wire [3:0] PE_IN = (PE_OE_N & ext) | (~PE_OE_N & PE_OUT);
  pemux_top i_dut (.*);
  pemux_core core (.clk(SYS_CLK), .addr(ADDR), .io(IO_SPACE), .wr(WR_EN),
    .rd(RD_EN), .wdata(WDATA));
  initial forever #25 SYS_CLK = ~SYS_CLK;
  // verdict and end of run
  task stop_test;
    if (mismatches == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // note read strobes and any detector-off moment
  always @(posedge SYS_CLK)
  begin
    rd_s <= RD_EN;
    if (BROWNOUT_DETECTOR_OFF === 1'h1)
      bod_seen <= 1'h1;
  end
  // each read result against the oldest note
  always @(negedge SYS_CLK)
    if (rd_s)
    begin
      exp_r = core.exp_q.pop_front();
      `CHK(RDATA, exp_r)
    end
  // watchdog far beyond the expected run length
  initial
  begin
    #500000;
    mismatches++;
    stop_test;
  end
  // main sequence
  initial
  begin
    repeat (6) @(negedge SYS_CLK);
    RST_N = 1'h1;
    // reset value, both spaces, unmapped places
    core.rdx(1'h0, 8'h55, 8'h00);
    core.acc(1'h1, 1'h0, 8'h35, 8'h12);
    core.acc(1'h1, 1'h1, 8'h35, 8'h10);
    core.rdx(1'h0, 8'h55, 8'h10);
    core.rdx(1'h1, 8'h55, 8'h00);
    // random port settings under both values of the pull-up disable
    for (int p = 1; p >= 0; p--)
    begin
      core.acc(1'h1, 1'h1, 8'h35, p ? 8'h10 : 8'h00);
      repeat (16)
      begin
        r = $random(seed);
        {PORTE_DIR, PORTE_OUT_LATCH} = r[7:0];
        repeat (2) @(negedge SYS_CLK);
        `CHK(PE_PULLUP, p ? 4'h0 : ~PORTE_DIR & PORTE_OUT_LATCH)
      end
    end
    // timed sleep-off set, sleep pulses, auto clear, late set refused
    fork
      core.bod_seq(0);
      repeat (12) @(negedge SYS_CLK) SLEEP_EXEC = ~SLEEP_EXEC;
    join
    core.rdx(1'h1, 8'h35, 8'h00);
    `CHK(bod_seen, 1'h1)
    core.bod_seq(6);
    core.rdx(1'h1, 8'h35, 8'h00);
    // vector move, block held to the next instruction
    for (int s = 1; s >= 0; s--)
    begin
      core.vec_seq(s[0]);
      `CHK(IRQ_BLOCK, 1'h1)
      INSTR_DONE = 1'h1;
      @(negedge SYS_CLK);
      INSTR_DONE = 1'h0;
      @(negedge SYS_CLK);
      `CHK(IRQ_BLOCK, 1'h0)
      // boot start for these fuses: top bit inverted over fuses, zeros
      `CHK(VECTOR_BASE, s ? 14'h3000 : 14'h0)
      core.acc(1'h1, 1'h1, 8'h35, 8'h00);
      core.rdx(1'h0, 8'h55, {6'h00, s[0], 1'h0});
      if (s)
      begin
        APPLICATION_LOCK_BIT = 1'h1;
        repeat (2) @(negedge SYS_CLK);
        `CHK(IRQ_BLOCK, 1'h1)
        IN_BOOT_SECTION = 1'h1;
        repeat (2) @(negedge SYS_CLK);
        `CHK(IRQ_BLOCK, 1'h0)
        {APPLICATION_LOCK_BIT, IN_BOOT_SECTION} = 2'h0;
      end
    end
    core.acc(1'h1, 1'h1, 8'h35, 8'h01);
    repeat (6) @(negedge SYS_CLK);
    `CHK(IRQ_BLOCK, 1'h0)
    core.rdx(1'h1, 8'h35, 8'h00);
    // random peripheral and pin traffic, watched by the checker
    repeat (64)
    begin
      @(negedge SYS_CLK);
      r = $random(seed);
      {SPI_UNIT2_ENABLE, SPI_MASTER_SELECT, SPI_UNIT2_DATA_OUT,
        TWOWIRE_ENABLE, TWOWIRE_CLOCK_DRIVE, TWOWIRE_DATA_DRIVE,
        COMP_OUT_ENABLE, COMP_OUT, PIN_CHANGE_MASK, ext} = r[15:0];
      {PIN_CHANGE_GROUP3_ENABLE, ADC_CH6_DIGITAL_DISABLE,
        ADC_CH7_DIGITAL_DISABLE} = r[18:16];
    end
    // short glitch on the released clock line is filtered out
    {TWOWIRE_ENABLE, TWOWIRE_CLOCK_DRIVE, TWOWIRE_DATA_DRIVE} = 3'h4;
    {COMP_OUT_ENABLE, SPI_UNIT2_ENABLE, ext} = 6'h0f;
    repeat (8) @(negedge SYS_CLK);
    #15 ext[1] = 1'h0;
    #20 ext[1] = 1'h1;
    repeat (8) @(negedge SYS_CLK) `CHK(TWOWIRE1_CLOCK_PIN, 1'h1)
    `CHK(TWOWIRE1_DATA_PIN, 1'h1)
    ext[1] = 1'h0;
    TWOWIRE_DATA_DRIVE = 1'h1;
    repeat (8) @(negedge SYS_CLK);
    `CHK(TWOWIRE1_CLOCK_PIN, 1'h0)
    `CHK(TWOWIRE1_DATA_PIN, 1'h0)
    // digital input enable from pin-change mask, group enable, adc
    {TWOWIRE_ENABLE, TWOWIRE_DATA_DRIVE, PORTE_DIR} = 6'h00;
    repeat (8)
    begin
      r = $random(seed);
      {PIN_CHANGE_MASK, PIN_CHANGE_GROUP3_ENABLE, ADC_CH7_DIGITAL_DISABLE,
        ADC_CH6_DIGITAL_DISABLE, ext} = r[10:0];
      dx = (r[10:7] & {4{r[6]}}) | {~r[5:4], 2'h3};
      repeat (6) @(negedge SYS_CLK);
      `CHK(PE_DIG_IN, dx & ext)
    end
    stop_test;
  end
endmodule
bind pemux_top pemux_chk #(.PC_W(PC_W)) i_chk (.*);
